// *** hw/adc_setup_params.svh ***
// Constants for the setup-byte decoder and reference sequencer.
// Assumes inclusion by bare name from the package and the decoder module.
`ifndef ADC_SETUP_PARAMS_SVH
`define ADC_SETUP_PARAMS_SVH

// Setup command byte layout
`define SETUP_ID_HI          7
`define SETUP_ID_LO          6
`define SETUP_ID_VALUE       2'b01
`define CLK_SEL_HI           5
`define CLK_SEL_LO           4
`define REF_SEL_HI           3
`define REF_SEL_LO           2
`define PAIR_SEL_HI          1
`define PAIR_SEL_LO          0

// Pair-mode data byte layout, upper nibble only
`define PAIR_FIELD_HI        7
`define PAIR_FIELD_LO        4

// Mode encodings
`define CLK_MODE_EXTERNAL    2'b11
`define REF_MODE_DEFAULT     2'b10
`define REF_EXT_ADC_BIT      0

// Reset values
`define CLK_SEL_RESET        2'b10
`define REF_SEL_RESET        `REF_MODE_DEFAULT
`define PAIR_CFG_RESET       4'h0

// Waits, counted in serial clock rising edges
`define REF_WAKE_CYCLES      9'd218
`define TEMP_REF_CYCLES      9'd244
`define TEMP_RESULT_CYCLES   9'd188
`define DELAY_WIDTH          9

`endif

// *** hw/adc_setup_pkg.sv ***
// Types for the setup decoder's sequencer states and state register.
// Assumes the constants header is on the include path.
`include "adc_setup_params.svh"

package adc_setup_pkg;

    typedef enum logic [1:0] {
        SEQ_IDLE     = 2'b00,
        SEQ_AIN_WAIT = 2'b01,
        SEQ_TEMP_REF = 2'b10,
        SEQ_TEMP_OUT = 2'b11
    } seq_state_t;

    typedef struct packed {
        seq_state_t  state;
        logic [2:0]  bit_count;
        logic [7:0]  shift;
        logic        data_pending;
        logic        data_to_bipolar;
        logic        sclk_prev;
        logic        cs_prev;
        logic [1:0]  clock_select;
        logic [1:0]  ref_select;
        logic [3:0]  unipolar;
        logic [3:0]  bipolar;
        logic        int_ref_on;
        logic        ref_waiting;
        logic        conv_go;
        logic        temp_measure;
        logic        temp_on_dout;
    } core_state_t;

endpackage : adc_setup_pkg

// *** hw/pin_sync.sv ***
// Two-stage synchroniser for a group of pin levels.
// Assumes inputs are asynchronous to clock_in; stage one feeds only stage two.
`timescale 1ns/1ns

module pin_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             clock_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] reset_value_in,
    input  wire logic [WIDTH-1:0] pins_in,
    output logic      [WIDTH-1:0] pins_out
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_state_t;

    sync_state_t sync_reg;
    sync_state_t sync_next;

    always_comb begin
        sync_next.stage1 = pins_in;
        sync_next.stage2 = sync_reg.stage1;
    end

    // Reset value is a tie-off constant from the parent, held idle-high for select
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            sync_reg <= {reset_value_in, reset_value_in};
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign pins_out = sync_reg.stage2;

endmodule : pin_sync

// *** hw/edge_delay_counter.sv ***
// Counts a given number of tick pulses and then pulses done for one cycle.
// Assumes tick is a one-cycle pulse on clock_in; a load restarts the count.
`timescale 1ns/1ns

module edge_delay_counter #(
    parameter int WIDTH = 9
) (
    input  wire logic             clock_in,
    input  wire logic             rst_n_in,
    input  wire logic             load_in,
    input  wire logic [WIDTH-1:0] load_value_in,
    input  wire logic             tick_in,
    output logic                  done_out
);

    typedef struct packed {
        logic [WIDTH-1:0] remaining;
        logic             done;
    } count_state_t;

    count_state_t cnt_reg;
    count_state_t cnt_next;

    always_comb begin
        cnt_next      = cnt_reg;
        cnt_next.done = 1'b0;
        if (load_in) begin
            cnt_next.remaining = load_value_in;
        end else if (tick_in && (cnt_reg.remaining != '0)) begin
            cnt_next.remaining = cnt_reg.remaining - 1'b1;
            cnt_next.done      = (cnt_reg.remaining == {{(WIDTH-1){1'b0}}, 1'b1});
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign done_out = cnt_reg.done;

endmodule : edge_delay_counter

// *** hw/adc_setup_ref_diff_select.sv ***
// Setup-byte decoder, pair-mode registers and reference sequencer.
// Assumes a host drives chip select, serial clock and data, MSB first,
// sampled on serial clock rising edges; conversion logic elsewhere raises
// one-cycle requests on clock_in and consumes the go and measure pulses.
//
// Summary of operation
// - Clock mode 11, internal ADC reference: shared internal reference off after scan
// - Clock mode 11, powered-down reference: wait 218 clocks first
// - Temperature in clock mode 11: reference on, wait 244 clocks
// - Clock mode 11: temperature result out 188 clocks later
// - External reference modes: no wake wait
// - Reference mode one-zero after reset
// - Pair select 0x: no data, registers unchanged
// - Pair select 10: data to unipolar
// - Pair select 11: data to bipolar
// - Unipolar bits 7..4 map pairs 0/1..6/7
// - Both pair registers reset to zero
// - Delays count host serial clock cycles
`timescale 1ns/1ns
`include "adc_setup_params.svh"

module adc_setup_ref_diff_select #(
    parameter int DELAY_WIDTH = `DELAY_WIDTH
) (
    input  wire logic       clock_in,
    input  wire logic       rst_n_in,
    input  wire logic       cs_n_in,
    input  wire logic       sclk_in,
    input  wire logic       sdata_in,
    input  wire logic       conv_request_in,
    input  wire logic       temp_request_in,
    input  wire logic       scan_done_in,
    output logic            pair01_unipolar_diff_out,
    output logic            pair23_unipolar_diff_out,
    output logic            pair45_unipolar_diff_out,
    output logic            pair67_unipolar_diff_out,
    output logic [3:0]      bipolar_pair_config_out,
    output logic [1:0]      clock_select_out,
    output logic [1:0]      ref_select_out,
    output logic            int_ref_on_out,
    output logic            ref_waiting_out,
    output logic            conv_go_out,
    output logic            temp_measure_out,
    output logic            temp_on_dout_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and delay counter

    logic [2:0]             pins_sync;
    logic                   cs_n_s;
    logic                   sclk_s;
    logic                   sdata_s;
    logic                   count_load;
    logic [DELAY_WIDTH-1:0] count_value;
    logic                   count_done;
    logic                   sclk_rise;

    pin_sync #(
        .WIDTH          (3)
    ) u_pin_sync (
        .clock_in       (clock_in),
        .rst_n_in       (rst_n_in),
        .reset_value_in (3'h4),
        .pins_in        ({cs_n_in, sclk_in, sdata_in}),
        .pins_out       (pins_sync)
    );

    assign cs_n_s  = pins_sync[2];
    assign sclk_s  = pins_sync[1];
    assign sdata_s = pins_sync[0];

    edge_delay_counter #(
        .WIDTH          (DELAY_WIDTH)
    ) u_delay (
        .clock_in       (clock_in),
        .rst_n_in       (rst_n_in),
        .load_in        (count_load),
        .load_value_in  (count_value),
        .tick_in        (sclk_rise),
        .done_out       (count_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // State

    adc_setup_pkg::core_state_t st_reg;
    adc_setup_pkg::core_state_t st_next;

    function automatic logic int_ref_for_adc(input logic [1:0] ref_sel);
        int_ref_for_adc = ~ref_sel[`REF_EXT_ADC_BIT];
    endfunction : int_ref_for_adc

    function automatic logic [DELAY_WIDTH-1:0] delay_of(input logic [8:0] cycles);
        delay_of = DELAY_WIDTH'(cycles);
    endfunction : delay_of

    assign sclk_rise = sclk_s & ~st_reg.sclk_prev;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        logic [7:0] shifted;
        logic       ext_mode;
        logic       int_adc;
        shifted  = {st_reg.shift[6:0], sdata_s};
        ext_mode = (st_reg.clock_select == `CLK_MODE_EXTERNAL);
        int_adc  = int_ref_for_adc(st_reg.ref_select);

        st_next              = st_reg;
        st_next.conv_go      = 1'b0;
        st_next.temp_measure = 1'b0;
        st_next.sclk_prev    = sclk_s;
        st_next.cs_prev      = cs_n_s;
        count_load           = 1'b0;
        count_value          = '0;

        // Serial receive: a byte frame restarts with each select
        if (cs_n_s) begin
            st_next.bit_count    = 3'h0;
            // Early release drops the awaited data byte
            st_next.data_pending = 1'b0;
        end else if (sclk_rise) begin
            st_next.shift     = shifted;
            st_next.bit_count = st_reg.bit_count + 3'h1;
            if (st_reg.bit_count == 3'h7) begin
                if (st_reg.data_pending) begin
                    st_next.data_pending = 1'b0;
                    if (st_reg.data_to_bipolar) begin
                        st_next.bipolar = shifted[`PAIR_FIELD_HI:`PAIR_FIELD_LO];
                    end else begin
                        st_next.unipolar = shifted[`PAIR_FIELD_HI:`PAIR_FIELD_LO];
                    end
                end else if (shifted[`SETUP_ID_HI:`SETUP_ID_LO] == `SETUP_ID_VALUE) begin
                    st_next.clock_select    = shifted[`CLK_SEL_HI:`CLK_SEL_LO];
                    st_next.ref_select      = shifted[`REF_SEL_HI:`REF_SEL_LO];
                    st_next.data_pending    = shifted[`PAIR_SEL_HI];
                    st_next.data_to_bipolar = shifted[`PAIR_SEL_LO];
                end
            end
        end

        // Result stays on the output until the host closes the next frame
        if (cs_n_s && !st_reg.cs_prev) begin
            st_next.temp_on_dout = 1'b0;
        end

        case (st_reg.state)
            adc_setup_pkg::SEQ_IDLE: begin
                if (temp_request_in) begin
                    st_next.temp_on_dout = 1'b0;
                    if (ext_mode) begin
                        st_next.int_ref_on  = 1'b1;
                        st_next.ref_waiting = 1'b1;
                        count_load          = 1'b1;
                        count_value         = delay_of(`TEMP_REF_CYCLES);
                        st_next.state       = adc_setup_pkg::SEQ_TEMP_REF;
                    end else begin
                        st_next.temp_measure = 1'b1;
                        st_next.temp_on_dout = 1'b1;
                    end
                end else if (conv_request_in) begin
                    if (!ext_mode || !int_adc || st_reg.int_ref_on) begin
                        st_next.conv_go = 1'b1;
                    end else begin
                        st_next.int_ref_on  = 1'b1;
                        st_next.ref_waiting = 1'b1;
                        count_load          = 1'b1;
                        count_value         = delay_of(`REF_WAKE_CYCLES);
                        st_next.state       = adc_setup_pkg::SEQ_AIN_WAIT;
                    end
                end else if (scan_done_in && ext_mode && int_adc) begin
                    st_next.int_ref_on = 1'b0;
                end
            end
            adc_setup_pkg::SEQ_AIN_WAIT: begin
                if (count_done) begin
                    st_next.conv_go     = 1'b1;
                    st_next.ref_waiting = 1'b0;
                    st_next.state       = adc_setup_pkg::SEQ_IDLE;
                end
            end
            adc_setup_pkg::SEQ_TEMP_REF: begin
                if (count_done) begin
                    st_next.temp_measure = 1'b1;
                    st_next.ref_waiting  = 1'b0;
                    count_load           = 1'b1;
                    count_value          = delay_of(`TEMP_RESULT_CYCLES);
                    st_next.state        = adc_setup_pkg::SEQ_TEMP_OUT;
                end
            end
            adc_setup_pkg::SEQ_TEMP_OUT: begin
                if (count_done) begin
                    st_next.temp_on_dout = 1'b1;
                    if (!int_adc) begin
                        st_next.int_ref_on = 1'b0;
                    end
                    st_next.state = adc_setup_pkg::SEQ_IDLE;
                end
            end
            default: begin
                st_next.state = adc_setup_pkg::SEQ_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            st_reg                 <= '0;
            st_reg.state           <= adc_setup_pkg::SEQ_IDLE;
            st_reg.cs_prev         <= 1'b1;
            st_reg.clock_select    <= `CLK_SEL_RESET;
            st_reg.ref_select      <= `REF_SEL_RESET;
            st_reg.unipolar        <= `PAIR_CFG_RESET;
            st_reg.bipolar         <= `PAIR_CFG_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign pair01_unipolar_diff_out = st_reg.unipolar[3];
    assign pair23_unipolar_diff_out = st_reg.unipolar[2];
    assign pair45_unipolar_diff_out = st_reg.unipolar[1];
    assign pair67_unipolar_diff_out = st_reg.unipolar[0];
    assign bipolar_pair_config_out  = st_reg.bipolar;
    assign clock_select_out         = st_reg.clock_select;
    assign ref_select_out           = st_reg.ref_select;
    assign int_ref_on_out           = st_reg.int_ref_on;
    assign ref_waiting_out          = st_reg.ref_waiting;
    assign conv_go_out              = st_reg.conv_go;
    assign temp_measure_out         = st_reg.temp_measure;
    assign temp_on_dout_out         = st_reg.temp_on_dout;

endmodule : adc_setup_ref_diff_select

// *** tb/adc_setup_sva.sv ***
// Checker for the setup decoder and reference sequencer.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns

module adc_setup_sva (
    input wire logic       clock_in,
    input wire logic       rst_n_in,
    input wire logic       sclk_in,
    input wire logic       conv_request_in,
    input wire logic       temp_request_in,
    input wire logic       scan_done_in,
    input wire logic       pair01_unipolar_diff_out,
    input wire logic       pair23_unipolar_diff_out,
    input wire logic       pair45_unipolar_diff_out,
    input wire logic       pair67_unipolar_diff_out,
    input wire logic [3:0] bipolar_pair_config_out,
    input wire logic [1:0] clock_select_out,
    input wire logic [1:0] ref_select_out,
    input wire logic       int_ref_on_out,
    input wire logic       ref_waiting_out,
    input wire logic       conv_go_out,
    input wire logic       temp_measure_out,
    input wire logic       temp_on_dout_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    ////////////////////////////////////////////////////////////////////////
    // Pin-level serial clock rises, counted loosely since the design syncs
    logic [8:0] rises_reg;
    logic [8:0] dout_reg;
    logic       temp_phase_reg;
    logic       quiet;
    assign quiet = !ref_waiting_out && !temp_phase_reg && !conv_request_in && !temp_request_in;

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            rises_reg      <= 9'h000;
            dout_reg       <= 9'h000;
            temp_phase_reg <= 1'b0;
        end else begin
            rises_reg      <= $rose(ref_waiting_out) ? 9'h000 : rises_reg + {8'h00, $rose(sclk_in)};
            dout_reg       <= temp_measure_out ? 9'h000 : dout_reg + {8'h00, $rose(sclk_in)};
            temp_phase_reg <= $rose(temp_on_dout_out) ? 1'b0 : (temp_measure_out | temp_phase_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_reset_vals;
        $rose(rst_n_in) |-> ref_select_out == 2'b10 && !int_ref_on_out && bipolar_pair_config_out == 4'h0 &&
            {pair01_unipolar_diff_out, pair23_unipolar_diff_out, pair45_unipolar_diff_out,
             pair67_unipolar_diff_out} == 4'h0;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");
    property p_go_pulse;
        conv_go_out |=> !conv_go_out;
    endproperty
    a_go_pulse: assert property (p_go_pulse) else $error("go pulse too long");
    property p_meas_pulse;
        temp_measure_out |=> !temp_measure_out;
    endproperty
    a_meas_pulse: assert property (p_meas_pulse) else $error("measure pulse too long");
    property p_wait_ref;
        ref_waiting_out |-> int_ref_on_out;
    endproperty
    a_wait_ref: assert property (p_wait_ref) else $error("wait without reference");
    property p_ext_no_wait;
        conv_request_in && !temp_request_in && ref_select_out[0] |=> !$rose(ref_waiting_out);
    endproperty
    a_ext_no_wait: assert property (p_ext_no_wait) else $error("wake wait in external mode");
    property p_warm_go;
        quiet && conv_request_in == 1'b0 ? 1'b0 : conv_request_in && !temp_request_in && !ref_waiting_out &&
            !temp_phase_reg && !$past(conv_request_in) && !$past(temp_request_in) &&
            (clock_select_out != 2'b11 || ref_select_out[0] || int_ref_on_out) |=> conv_go_out;
    endproperty
    a_warm_go: assert property (p_warm_go) else $error("conversion not started at once");
    property p_scan_off;
        scan_done_in && quiet && !$past(conv_request_in) && !$past(temp_request_in) &&
            clock_select_out == 2'b11 && !ref_select_out[0] |=> !int_ref_on_out;
    endproperty
    a_scan_off: assert property (p_scan_off) else $error("reference kept on after scan");
    property p_conv_len;
        $fell(ref_waiting_out) && conv_go_out |-> rises_reg inside {[216:220]};
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("wake wait length wrong");
    property p_temp_len;
        $fell(ref_waiting_out) && temp_measure_out |-> rises_reg inside {[242:246]};
    endproperty
    a_temp_len: assert property (p_temp_len) else $error("temperature wait length wrong");
    property p_dout_len;
        $rose(temp_on_dout_out) && clock_select_out == 2'b11 |-> dout_reg inside {[186:190]};
    endproperty
    a_dout_len: assert property (p_dout_len) else $error("result delay wrong");
endmodule : adc_setup_sva

bind adc_setup_ref_diff_select adc_setup_sva adc_setup_sva_inst (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .sclk_in(sclk_in), .conv_request_in(conv_request_in),
    .temp_request_in(temp_request_in), .scan_done_in(scan_done_in),
    .pair01_unipolar_diff_out(pair01_unipolar_diff_out), .pair23_unipolar_diff_out(pair23_unipolar_diff_out),
    .pair45_unipolar_diff_out(pair45_unipolar_diff_out), .pair67_unipolar_diff_out(pair67_unipolar_diff_out),
    .bipolar_pair_config_out(bipolar_pair_config_out), .clock_select_out(clock_select_out),
    .ref_select_out(ref_select_out), .int_ref_on_out(int_ref_on_out), .ref_waiting_out(ref_waiting_out),
    .conv_go_out(conv_go_out), .temp_measure_out(temp_measure_out), .temp_on_dout_out(temp_on_dout_out));

// *** tb/serial_host_model.sv ***
// Host controller model: chip select, serial clock and data, MSB first.
// Assumes a 100 ns clock_in; serial clock period is eight of those.
`timescale 1ns/1ns

module serial_host_model (
    input  wire logic clock_in,
    output logic      cs_n_out,
    output logic      sclk_out,
    output logic      sdata_out
);
    initial begin
        cs_n_out  = 1'b1;
        sclk_out  = 1'b0;
        sdata_out = 1'b0;
    end

    task automatic half();
        repeat (4) @(posedge clock_in);
    endtask : half

    task automatic frame(input logic [15:0] d, input int n);
        @(posedge clock_in) cs_n_out <= 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            sdata_out <= d[i];
            half();
            sclk_out <= 1'b1;
            half();
            sclk_out <= 1'b0;
        end
        half();
        cs_n_out  <= 1'b1;
        sdata_out <= ~sdata_out;
    endtask : frame

    task automatic clocks(input int n);
        repeat (n) begin
            half();
            sclk_out  <= 1'b1;
            sdata_out <= ~sdata_out;
            half();
            sclk_out  <= 1'b0;
        end
    endtask : clocks
endmodule : serial_host_model

// *** tb/tb.sv ***
// Self-checking bench for the setup decoder and reference sequencer.
// Assumes the host model drives the serial pins; bench drives requests.
`timescale 1ns/1ns

module tb;
    logic       clock_in = 1'b0;
    logic       rst_n_in = 1'b0;
    logic       conv_request_in = 1'b0;
    logic       temp_request_in = 1'b0;
    logic       scan_done_in = 1'b0;
    wire        cs_n, sclk, sdata;
    logic [3:0] pairs, bip;
    logic [1:0] clk_sel, ref_sel;
    logic       ref_on, waiting, go, meas, dout_temp;
    int         n_fail = 0, comparisons = 0, n_go = 0, n_meas = 0, exp_uni = 0, exp_bip = 0;
    logic [31:0] seed = 32'hc22366a5;

    always #50 clock_in = ~clock_in;

    serial_host_model serial_host_model_inst (.clock_in(clock_in), .cs_n_out(cs_n), .sclk_out(sclk),
        .sdata_out(sdata));
    adc_setup_ref_diff_select adc_setup_ref_diff_select_inst (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .cs_n_in(cs_n), .sclk_in(sclk), .sdata_in(sdata), .conv_request_in(conv_request_in),
        .temp_request_in(temp_request_in), .scan_done_in(scan_done_in), .pair01_unipolar_diff_out(pairs[3]),
        .pair23_unipolar_diff_out(pairs[2]), .pair45_unipolar_diff_out(pairs[1]),
        .pair67_unipolar_diff_out(pairs[0]), .bipolar_pair_config_out(bip), .clock_select_out(clk_sel),
        .ref_select_out(ref_sel), .int_ref_on_out(ref_on), .ref_waiting_out(waiting), .conv_go_out(go),
        .temp_measure_out(meas), .temp_on_dout_out(dout_temp));

    always @(posedge clock_in) begin
        if (go === 1'b1) n_go++;
        if (meas === 1'b1) n_meas++;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge clock_in);
    endtask : cyc

    // One-cycle request: 0 conversion, 1 temperature, 2 scan finished
    task automatic req(input int k);
        @(posedge clock_in);
        conv_request_in <= (k == 0);
        temp_request_in <= (k == 1);
        scan_done_in    <= (k == 2);
        @(posedge clock_in);
        {conv_request_in, temp_request_in, scan_done_in} <= 3'b000;
    endtask : req

    task automatic test_done();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////////
    // Longest path is about 6000 cycles of serial traffic
    initial begin
        #1500000;
        n_fail++;
        test_done();
    end

    initial begin
        logic [31:0] v;
        logic [7:0]  b;
        repeat (3) @(posedge clock_in);
        rst_n_in <= 1'b1;
        cyc(4);
        chk({pairs, bip, clk_sel, ref_sel, ref_on}, {8'h00, 2'b10, 2'b10, 1'b0});
        $display("test reset done");
        // Trailing byte after a 0x select carries a non-setup id and must be dropped
        for (int d = 0; d < 4; d++) begin
            v = xs();
            b = (d < 2) ? (v[15:8] | 8'hc0) : v[15:8];
            serial_host_model_inst.frame({2'b01, v[5:2], d[1:0], b}, 16);
            if (d == 2) exp_uni = b[7:4];
            if (d == 3) exp_bip = b[7:4];
            cyc(8);
            chk({clk_sel, ref_sel, pairs, bip}, {v[5:2], exp_uni[3:0], exp_bip[3:0]});
        end
        $display("test pair select done");
        serial_host_model_inst.frame(16'h7800, 8);
        req(0);
        cyc(3);
        chk({ref_on, waiting}, 2'b11);
        serial_host_model_inst.clocks(217);
        cyc(6);
        chk(n_go, 0);
        serial_host_model_inst.clocks(1);
        cyc(6);
        chk({n_go[3:0], waiting}, {4'h1, 1'b0});
        req(0);
        cyc(2);
        chk({n_go[3:0], waiting}, {4'h2, 1'b0});
        req(2);
        cyc(2);
        chk(ref_on, 1'b0);
        $display("test reference wake done");
        serial_host_model_inst.frame(16'h7400, 8);
        req(0);
        cyc(2);
        chk({n_go[3:0], ref_on, waiting}, {4'h3, 2'b00});
        $display("test external reference done");
        req(1);
        cyc(3);
        chk(waiting, 1'b1);
        // A random request during the wait must be refused
        v = xs();
        req(v[0] ? 0 : 2);
        cyc(2);
        chk({n_go[3:0], waiting}, {4'h3, 1'b1});
        serial_host_model_inst.clocks(243);
        cyc(6);
        chk(n_meas, 0);
        serial_host_model_inst.clocks(1);
        cyc(6);
        chk(n_meas, 1);
        serial_host_model_inst.clocks(187);
        cyc(6);
        chk(dout_temp, 1'b0);
        serial_host_model_inst.clocks(1);
        cyc(6);
        chk({dout_temp, ref_on}, 2'b10);
        $display("test temperature done");
        test_done();
    end
endmodule : tb
